// [verilog/timer_pkg.sv]
package timer_pkg;
    // Special-function register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_ZERO_LOW = 8'h8a;
    localparam logic [7:0] ADDR_ONE_LOW = 8'h8b;
    localparam logic [7:0] ADDR_ZERO_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_ONE_HIGH = 8'h8d;
    localparam logic [7:0] ADDR_CLOCK_DIV = 8'h8e;
    // Reset values
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_CLOCK_DIV = 8'h01;
    // Mode register field positions
    localparam int MODE_ZERO_LSB = 0;
    localparam int SELECT_ZERO_BIT = 2;
    localparam int GATE_ZERO_BIT = 3;
    localparam int MODE_ONE_LSB = 4;
    localparam int SELECT_ONE_BIT = 6;
    localparam int GATE_ONE_BIT = 7;
    // Control register field positions
    localparam int RUN_ZERO_BIT = 4;
    localparam int OVERFLOW_ZERO_BIT = 5;
    localparam int RUN_ONE_BIT = 6;
    localparam int OVERFLOW_ONE_BIT = 7;
    // Clock divide register field positions
    localparam int DIVIDE_SEL_ZERO_BIT = 3;
    localparam int DIVIDE_SEL_ONE_BIT = 4;
    // Event pin positions on port 0
    localparam int EVENT_PIN_ZERO_BIT = 5;
    localparam int EVENT_PIN_ONE_BIT = 6;
    // Prescaler terminal counts
    localparam logic [3:0] DIV_FAST_LAST = 4'h3;
    localparam logic [3:0] DIV_SLOW_LAST = 4'hb;
    // Count widths
    localparam logic [7:0] MASK_13_LOW = 8'h1f;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } count_mode_t;

    // Register bus write or read request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;
endpackage

// [verilog/event_edge.sv]
`timescale 1ns/1ns
// Two-stage synchroniser and falling-edge detect for an event pin
module event_edge (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pin and pulse
    input wire logic pin,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Only sync_q and later are looked at, never meta_q
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign fall = last_q & ~sync_q;
endmodule

// [verilog/timer_counter_zero_one.sv]
`timescale 1ns/1ns
// How it works
// - Timer from CPU clock or event pin
// - Event pins are port 0 bits 5, 6
// - 16-bit count as low, high bytes
// - Modes: 13-bit, 16-bit, reload, split
// - Split mode only on timer zero
// - Timer one gate needs pin high and run
// - Timer zero gate needs pin high and run
// - Timer one divides by 4 or 12
// - Timer zero divides by 4 or 12
// - Timer one fields in mode bits 7:4
// - Timer zero mode in bits 1:0
// - Overflow flag set, cleared on vector
module timer_counter_zero_one (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Special-function register bus
    input wire timer_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Interrupt vector acknowledges from the CPU
    input wire logic vector_ack_zero,
    input wire logic vector_ack_one,
    // Pins
    input wire logic [7:0] port0_pins,
    input wire logic ext_irq_zero_pin,
    input wire logic ext_irq_one_pin,
    // Overflow flags toward the interrupt controller
    output logic overflow_zero,
    output logic overflow_one
);
    logic [7:0] timer_mode_select_q;
    logic [7:0] control_q;
    logic [7:0] clock_divide_control_q;
    logic [7:0] count_zero_low_q;
    logic [7:0] count_zero_high_q;
    logic [7:0] count_one_low_q;
    logic [7:0] count_one_high_q;
    logic [3:0] div_q;
    logic [3:0] div_slow_q;
    logic tick_fast;
    logic tick_slow;
    logic event_pin_zero;
    logic event_pin_one;
    logic fall_zero;
    logic fall_one;
    logic run_zero;
    logic run_one;
    logic step_zero;
    logic step_one;
    logic step_split_high;
    logic wrap_zero;
    logic wrap_zero_high;
    logic wrap_one;
    timer_pkg::count_mode_t mode_zero;
    timer_pkg::count_mode_t mode_one;

    assign event_pin_zero = port0_pins[timer_pkg::EVENT_PIN_ZERO_BIT];
    assign event_pin_one = port0_pins[timer_pkg::EVENT_PIN_ONE_BIT];

    // Field decode of the mode register
    assign mode_zero = timer_pkg::count_mode_t'(timer_mode_select_q[timer_pkg::MODE_ZERO_LSB +: 2]);
    assign mode_one = timer_pkg::count_mode_t'(timer_mode_select_q[timer_pkg::MODE_ONE_LSB +: 2]);

    // Free-running prescalers for CPU clock / 4 and / 12
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_q <= 4'h0;
            div_slow_q <= 4'h0;
        end else begin
            div_q <= (div_q == timer_pkg::DIV_FAST_LAST) ? 4'h0 : div_q + 4'h1;
            div_slow_q <= (div_slow_q == timer_pkg::DIV_SLOW_LAST) ? 4'h0 : div_slow_q + 4'h1;
        end
    end
    assign tick_fast = (div_q == timer_pkg::DIV_FAST_LAST);
    assign tick_slow = (div_slow_q == timer_pkg::DIV_SLOW_LAST);

    event_edge sync_zero (
        .clock(clock),
        .rst(rst),
        .pin(event_pin_zero),
        .fall(fall_zero)
    );
    event_edge sync_one (
        .clock(clock),
        .rst(rst),
        .pin(event_pin_one),
        .fall(fall_one)
    );

    // Gating: run bit alone, or run bit and external pin high
    assign run_zero = control_q[timer_pkg::RUN_ZERO_BIT]
        & (~timer_mode_select_q[timer_pkg::GATE_ZERO_BIT] | ext_irq_zero_pin);
    assign run_one = control_q[timer_pkg::RUN_ONE_BIT]
        & (~timer_mode_select_q[timer_pkg::GATE_ONE_BIT] | ext_irq_one_pin);

    // Clock source: event edge or divided CPU clock
    always_comb begin
        step_zero = 1'b0;
        step_one = 1'b0;
        if (timer_mode_select_q[timer_pkg::SELECT_ZERO_BIT]) begin
            step_zero = fall_zero;
        end else begin
            step_zero = clock_divide_control_q[timer_pkg::DIVIDE_SEL_ZERO_BIT] ? tick_fast : tick_slow;
        end
        if (timer_mode_select_q[timer_pkg::SELECT_ONE_BIT]) begin
            step_one = fall_one;
        end else begin
            step_one = clock_divide_control_q[timer_pkg::DIVIDE_SEL_ONE_BIT] ? tick_fast : tick_slow;
        end
        step_split_high = step_zero & control_q[timer_pkg::RUN_ONE_BIT];
        step_zero = step_zero & run_zero;
        step_one = step_one & run_one;
    end

    // Overflow detection per mode
    always_comb begin
        wrap_zero = 1'b0;
        wrap_zero_high = 1'b0;
        wrap_one = 1'b0;
        case (mode_zero)
            timer_pkg::MODE_13BIT: wrap_zero = step_zero & (&count_zero_high_q)
                & (&(count_zero_low_q | ~timer_pkg::MASK_13_LOW));
            timer_pkg::MODE_16BIT: wrap_zero = step_zero & (&count_zero_high_q) & (&count_zero_low_q);
            timer_pkg::MODE_RELOAD: wrap_zero = step_zero & (&count_zero_low_q);
            timer_pkg::MODE_SPLIT: begin
                wrap_zero = step_zero & (&count_zero_low_q);
                wrap_zero_high = step_split_high & (&count_zero_high_q);
            end
            default: wrap_zero = 1'b0;
        endcase
        case (mode_one)
            timer_pkg::MODE_13BIT: wrap_one = step_one & (&count_one_high_q)
                & (&(count_one_low_q | ~timer_pkg::MASK_13_LOW));
            timer_pkg::MODE_16BIT: wrap_one = step_one & (&count_one_high_q) & (&count_one_low_q);
            timer_pkg::MODE_RELOAD: wrap_one = step_one & (&count_one_low_q);
            default: wrap_one = 1'b0; // Split mode holds timer one still
        endcase
    end

    // Timer zero count; CPU writes take priority over counting
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_zero_low_q <= timer_pkg::RESET_ZERO;
            count_zero_high_q <= timer_pkg::RESET_ZERO;
        end else begin
            case (mode_zero)
                timer_pkg::MODE_13BIT: if (step_zero) begin
                    count_zero_low_q <= (count_zero_low_q + 8'h01) & timer_pkg::MASK_13_LOW;
                    if ((count_zero_low_q & timer_pkg::MASK_13_LOW) == timer_pkg::MASK_13_LOW) begin
                        count_zero_high_q <= count_zero_high_q + 8'h01;
                    end
                end
                timer_pkg::MODE_16BIT: if (step_zero) begin
                    {count_zero_high_q, count_zero_low_q} <= {count_zero_high_q, count_zero_low_q} + 16'h0001;
                end
                timer_pkg::MODE_RELOAD: if (step_zero) begin
                    count_zero_low_q <= wrap_zero ? count_zero_high_q : count_zero_low_q + 8'h01;
                end
                timer_pkg::MODE_SPLIT: begin
                    if (step_zero) begin
                        count_zero_low_q <= count_zero_low_q + 8'h01;
                    end
                    if (step_split_high) begin
                        count_zero_high_q <= count_zero_high_q + 8'h01;
                    end
                end
                default: count_zero_low_q <= count_zero_low_q;
            endcase
            if (sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_ZERO_LOW) begin
                count_zero_low_q <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_ZERO_HIGH) begin
                count_zero_high_q <= sfr_req.wdata;
            end
        end
    end

    // Timer one count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_one_low_q <= timer_pkg::RESET_ZERO;
            count_one_high_q <= timer_pkg::RESET_ZERO;
        end else begin
            case (mode_one)
                timer_pkg::MODE_13BIT: if (step_one) begin
                    count_one_low_q <= (count_one_low_q + 8'h01) & timer_pkg::MASK_13_LOW;
                    if ((count_one_low_q & timer_pkg::MASK_13_LOW) == timer_pkg::MASK_13_LOW) begin
                        count_one_high_q <= count_one_high_q + 8'h01;
                    end
                end
                timer_pkg::MODE_16BIT: if (step_one) begin
                    {count_one_high_q, count_one_low_q} <= {count_one_high_q, count_one_low_q} + 16'h0001;
                end
                timer_pkg::MODE_RELOAD: if (step_one) begin
                    count_one_low_q <= wrap_one ? count_one_high_q : count_one_low_q + 8'h01;
                end
                default: count_one_low_q <= count_one_low_q;
            endcase
            if (sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_ONE_LOW) begin
                count_one_low_q <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_ONE_HIGH) begin
                count_one_high_q <= sfr_req.wdata;
            end
        end
    end

    // Mode and clock divide registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timer_mode_select_q <= timer_pkg::RESET_ZERO;
            clock_divide_control_q <= timer_pkg::RESET_CLOCK_DIV;
        end else begin
            if (sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_MODE) begin
                timer_mode_select_q <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_CLOCK_DIV) begin
                clock_divide_control_q <= sfr_req.wdata;
            end
        end
    end

    // Control register; overflow set wins over a same-cycle clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            control_q <= timer_pkg::RESET_ZERO;
        end else begin
            if (sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_CONTROL) begin
                control_q <= sfr_req.wdata;
            end
            if (vector_ack_zero) begin
                control_q[timer_pkg::OVERFLOW_ZERO_BIT] <= 1'b0;
            end
            if (vector_ack_one) begin
                control_q[timer_pkg::OVERFLOW_ONE_BIT] <= 1'b0;
            end
            if (wrap_zero) begin
                control_q[timer_pkg::OVERFLOW_ZERO_BIT] <= 1'b1;
            end
            // Split mode lends timer one's flag to timer zero's high byte
            if (wrap_one || wrap_zero_high) begin
                control_q[timer_pkg::OVERFLOW_ONE_BIT] <= 1'b1;
            end
        end
    end

    // Read data is registered, one cycle after the request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sfr_rdata <= timer_pkg::RESET_ZERO;
            sfr_hit <= 1'b0;
        end else begin
            sfr_hit <= sfr_req.rd;
            case (sfr_req.addr)
                timer_pkg::ADDR_CONTROL: sfr_rdata <= control_q;
                timer_pkg::ADDR_MODE: sfr_rdata <= timer_mode_select_q;
                timer_pkg::ADDR_ZERO_LOW: sfr_rdata <= count_zero_low_q;
                timer_pkg::ADDR_ONE_LOW: sfr_rdata <= count_one_low_q;
                timer_pkg::ADDR_ZERO_HIGH: sfr_rdata <= count_zero_high_q;
                timer_pkg::ADDR_ONE_HIGH: sfr_rdata <= count_one_high_q;
                timer_pkg::ADDR_CLOCK_DIV: sfr_rdata <= clock_divide_control_q;
                default: sfr_rdata <= timer_pkg::RESET_ZERO;
            endcase
        end
    end

    assign overflow_zero = control_q[timer_pkg::OVERFLOW_ZERO_BIT];
    assign overflow_one = control_q[timer_pkg::OVERFLOW_ONE_BIT];
endmodule

// [test/timer_checker_assertions.sv]
`timescale 1ns/1ns
// Watches the timer block's bus and flag ports
module timer_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire timer_pkg::sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Acknowledges and pins
    input wire logic vector_ack_zero,
    input wire logic vector_ack_one,
    input wire logic [7:0] port0_pins,
    input wire logic ext_irq_zero_pin,
    input wire logic ext_irq_one_pin,
    // Flags
    input wire logic overflow_zero,
    input wire logic overflow_one
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic mapped;
    // Addresses the block answers
    assign mapped = sfr_req.addr >= timer_pkg::ADDR_CONTROL && sfr_req.addr <= timer_pkg::ADDR_CLOCK_DIV;
    chk_hit_after_read: assert property (sfr_req.rd |=> sfr_hit)
        else $error("hit missing after read");
    chk_no_stray_hit: assert property (!sfr_req.rd |=> !sfr_hit)
        else $error("hit without read");
    chk_unmapped_reads_zero: assert property (sfr_req.rd && !mapped |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_mode_read_back: assert property ((sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_MODE) ##1 !sfr_req.wr
        ##1 (sfr_req.rd && !sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_MODE) |=> sfr_rdata == $past(sfr_req.wdata, 3))
        else $error("mode read back wrong");
    chk_control_shows_flags: assert property (sfr_req.rd && sfr_req.addr == timer_pkg::ADDR_CONTROL |=>
        sfr_rdata[7] == $past(overflow_one) && sfr_rdata[5] == $past(overflow_zero))
        else $error("control flags mismatch");
    chk_ack_clears_zero: assert property ((vector_ack_zero && !sfr_req.wr) [*2] |=>
        !(overflow_zero && $past(overflow_zero))) else $error("ack zero did not clear");
    chk_zero_falls_by_cause: assert property ($fell(overflow_zero) |-> $past(vector_ack_zero) || $past(sfr_req.wr))
        else $error("flag zero fell alone");
    chk_one_falls_by_cause: assert property ($fell(overflow_one) |-> $past(vector_ack_one) || $past(sfr_req.wr))
        else $error("flag one fell alone");
    // Main scenarios reached
    cover property (sfr_req.rd && !mapped);
    cover property ($rose(overflow_zero));
    cover property ($rose(overflow_one));
    cover property (overflow_zero && $rose(overflow_one));
endmodule

// [test/cpu_sfr_model.sv]
`timescale 1ns/1ns
// CPU side of the register bus; one access per call, held one cycle
module cpu_sfr_model (
    // Clock
    input wire logic clock,
    // Register bus
    output timer_pkg::sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Vector acknowledges
    output logic vector_ack_zero,
    output logic vector_ack_one
);
    // Idle bus at time zero
    initial begin
        sfr_req = '0;
        vector_ack_zero = 1'b0;
        vector_ack_one = 1'b0;
    end
    // Run bits reach the timer only through this write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clock);
        sfr_req <= '0;
    endtask
    // Data is registered, so it is taken mid-cycle after the request edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic h);
        @(posedge clock);
        sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        sfr_req <= '0;
        @(negedge clock);
        v = sfr_rdata;
        h = sfr_hit;
    endtask
    // Vectoring to a service routine, two cycles long
    task automatic ack(input logic one);
        @(posedge clock);
        if (one) vector_ack_one <= 1'b1;
        else vector_ack_zero <= 1'b1;
        repeat (2) @(posedge clock);
        vector_ack_zero <= 1'b0;
        vector_ack_one <= 1'b0;
    endtask
endmodule

// [test/timer_counter_zero_one_tb.sv]
`timescale 1ns/1ns
// Self-checking bench for timers zero and one
module timer_counter_zero_one_tb;
    logic clock;
    logic rst;
    timer_pkg::sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic vector_ack_zero;
    logic vector_ack_one;
    logic [7:0] port0_pins;
    logic ext_irq_zero_pin;
    logic ext_irq_one_pin;
    logic overflow_zero;
    logic overflow_one;
    int n_fail;
    int cmp_count;
    int cycles;
    logic [7:0] d;
    logic h;
    timer_counter_zero_one DUT (.clock, .rst, .sfr_req, .sfr_rdata, .sfr_hit, .vector_ack_zero, .vector_ack_one,
        .port0_pins, .ext_irq_zero_pin, .ext_irq_one_pin, .overflow_zero, .overflow_one);
    cpu_sfr_model cpu (.clock, .sfr_req, .sfr_rdata, .sfr_hit, .vector_ack_zero, .vector_ack_one);
    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        cpu.rd(a, d, h);
        check(d, exp);
        check({7'h00, h}, 8'h01);
    endtask
    // Event pin low for three cycles, then settle past the synchroniser
    task automatic pulse(input int b);
        @(posedge clock);
        port0_pins[b] <= 1'b0;
        repeat (3) @(posedge clock);
        port0_pins[b] <= 1'b1;
        repeat (6) @(posedge clock);
    endtask
    task automatic t_reset;
        rd_chk(timer_pkg::ADDR_MODE, timer_pkg::RESET_ZERO);
        rd_chk(timer_pkg::ADDR_CONTROL, timer_pkg::RESET_ZERO);
        rd_chk(timer_pkg::ADDR_CLOCK_DIV, timer_pkg::RESET_CLOCK_DIV);
        cpu.wr(8'h8f, 8'h55);
        rd_chk(8'h8f, 8'h00);
        cpu.wr(timer_pkg::ADDR_MODE, 8'ha5);
        rd_chk(timer_pkg::ADDR_MODE, 8'ha5);
        $display("test reset done");
    endtask
    // Fast prescaler wraps 0xfffe within a few ticks, then the gate is tried
    task automatic t_timer;
        cpu.wr(timer_pkg::ADDR_ZERO_LOW, 8'hfe);
        cpu.wr(timer_pkg::ADDR_ZERO_HIGH, 8'hff);
        cpu.wr(timer_pkg::ADDR_CLOCK_DIV, 8'h08);
        cpu.wr(timer_pkg::ADDR_MODE, 8'h01);
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h10);
        for (int i = 0; i < 12 && overflow_zero !== 1'b1; i++) @(negedge clock);
        check({7'h00, overflow_zero}, 8'h01);
        rd_chk(timer_pkg::ADDR_ZERO_HIGH, 8'h00);
        rd_chk(timer_pkg::ADDR_CONTROL, 8'h30);
        cpu.ack(1'b0);
        @(negedge clock);
        check({7'h00, overflow_zero}, 8'h00);
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h00);
        cpu.wr(timer_pkg::ADDR_MODE, 8'h09);
        cpu.wr(timer_pkg::ADDR_ZERO_LOW, 8'h00);
        ext_irq_zero_pin <= 1'b0;
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h10);
        repeat (40) @(posedge clock);
        rd_chk(timer_pkg::ADDR_ZERO_LOW, 8'h00);
        ext_irq_zero_pin <= 1'b1;
        repeat (40) @(posedge clock);
        cpu.rd(timer_pkg::ADDR_ZERO_LOW, d, h);
        check({7'h00, d != 8'h00}, 8'h01);
        $display("test timer done");
    endtask
    // Timer one counts its own pin only, then reloads from the high byte
    task automatic t_counter;
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h00);
        cpu.wr(timer_pkg::ADDR_MODE, 8'h50);
        cpu.wr(timer_pkg::ADDR_ONE_LOW, 8'h00);
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h40);
        repeat (3) pulse(6);
        pulse(5);
        rd_chk(timer_pkg::ADDR_ONE_LOW, 8'h03);
        cpu.wr(timer_pkg::ADDR_MODE, 8'h60);
        cpu.wr(timer_pkg::ADDR_ONE_HIGH, 8'hf0);
        cpu.wr(timer_pkg::ADDR_ONE_LOW, 8'hff);
        pulse(6);
        check({7'h00, overflow_one}, 8'h01);
        rd_chk(timer_pkg::ADDR_ONE_LOW, 8'hf0);
        cpu.ack(1'b1);
        @(negedge clock);
        check({7'h00, overflow_one}, 8'h00);
        // Gate on: a low gate pin blocks the edge, a high one passes it
        cpu.wr(timer_pkg::ADDR_MODE, 8'hd0);
        cpu.wr(timer_pkg::ADDR_ONE_LOW, 8'h00);
        ext_irq_one_pin <= 1'b0;
        pulse(6);
        rd_chk(timer_pkg::ADDR_ONE_LOW, 8'h00);
        @(posedge clock);
        ext_irq_one_pin <= 1'b1;
        pulse(6);
        rd_chk(timer_pkg::ADDR_ONE_LOW, 8'h01);
        $display("test counter done");
    endtask
    // Split mode: timer zero high byte runs on run one and sets flag one
    task automatic t_split;
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h00);
        cpu.wr(timer_pkg::ADDR_MODE, 8'h37);
        cpu.wr(timer_pkg::ADDR_ZERO_LOW, 8'hff);
        cpu.wr(timer_pkg::ADDR_ZERO_HIGH, 8'hff);
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h50);
        pulse(5);
        rd_chk(timer_pkg::ADDR_CONTROL, 8'hf0);
        rd_chk(timer_pkg::ADDR_ZERO_HIGH, 8'h00);
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h40);
        pulse(5);
        rd_chk(timer_pkg::ADDR_ZERO_LOW, 8'h00);
        rd_chk(timer_pkg::ADDR_ZERO_HIGH, 8'h01);
        $display("test split done");
    endtask
    // Timer one on the CPU clock: 50 run edges give 12-13 ticks at /4, 4-5 at /12
    task automatic t_divide;
        for (int k = 0; k < 2; k++) begin
            cpu.wr(timer_pkg::ADDR_CONTROL, 8'h00);
            cpu.wr(timer_pkg::ADDR_MODE, 8'h10);
            cpu.wr(timer_pkg::ADDR_CLOCK_DIV, (k == 0) ? 8'h10 : 8'h00);
            cpu.wr(timer_pkg::ADDR_ONE_LOW, 8'h00);
            cpu.wr(timer_pkg::ADDR_ONE_HIGH, 8'h00);
            cpu.wr(timer_pkg::ADDR_CONTROL, 8'h40);
            repeat (48) @(posedge clock);
            cpu.wr(timer_pkg::ADDR_CONTROL, 8'h00);
            cpu.rd(timer_pkg::ADDR_ONE_LOW, d, h);
            check({7'h00, (k == 0) ? (d == 8'h0c || d == 8'h0d) : (d == 8'h04 || d == 8'h05)}, 8'h01);
        end
        $display("test divide done");
    endtask
    // Thirteen-bit carry on timer zero; timer one in split mode holds
    task automatic t_thirteen;
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h00);
        cpu.wr(timer_pkg::ADDR_MODE, 8'h34);
        cpu.wr(timer_pkg::ADDR_ONE_LOW, 8'h11);
        cpu.wr(timer_pkg::ADDR_ZERO_LOW, 8'h1f);
        cpu.wr(timer_pkg::ADDR_ZERO_HIGH, 8'h00);
        cpu.wr(timer_pkg::ADDR_CONTROL, 8'h50);
        pulse(5);
        pulse(6);
        rd_chk(timer_pkg::ADDR_ZERO_LOW, 8'h00);
        rd_chk(timer_pkg::ADDR_ZERO_HIGH, 8'h01);
        rd_chk(timer_pkg::ADDR_ONE_LOW, 8'h11);
        $display("test thirteen done");
    endtask
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        rst = 1'b1;
        port0_pins = 8'hff;
        ext_irq_zero_pin = 1'b1;
        ext_irq_one_pin = 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_timer();
        t_counter();
        t_thirteen();
        t_split();
        t_divide();
        report_and_stop();
    end
endmodule
bind timer_counter_zero_one timer_checker chk (.clock, .rst, .sfr_req, .sfr_rdata, .sfr_hit, .vector_ack_zero,
    .vector_ack_one, .port0_pins, .ext_irq_zero_pin, .ext_irq_one_pin, .overflow_zero, .overflow_one);
